/* sep_pkg.sv */
// Shared constants for the serial memory command link
// How it works
// - ORG high or open selects 16-bit words
// - Power-up reset leaves programming locked
// - Two-bit op-code then 8 or 9 address bits
// - Select raised, first sampled one starts instruction
// - Read 10, write 01, erase 11, addressed
// - Op-code 00 picks lock/unlock/clear/fill
// - Top address bit is ignored
// - Read outputs zero then data, MSB first
// - Read data output changes only on serial clock rise
// - Held select streams next words, no zero
// - Unlocked until lock instruction or power loss
// - Reads work whether locked or not
// - Host should lock after each write; sep_host never sends a lock by itself
// - Erase sets location to ones on select fall
// - Select falls before next clock after data
// - Write erases location automatically first
// - Program cycle timed internally, clock irrelevant
// - Busy drives output low while select high, input ignored
// - Clear-all sets array to ones on select fall
// - Fill-all writes one value everywhere
// - Ready held until start bit or select low
// - Program cycle lasts at most 10 ms
// - Select low at least 250 ns between instructions
package sep_pkg;
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] SUB_LOCK = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_CLEAR = 2'h2;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;
  localparam int OP_BITS = 2;
  localparam int ADDR_BITS_X16 = 8;
  localparam int ADDR_BITS_X8 = 9;
  localparam int DATA_BITS_X16 = 16;
  localparam int DATA_BITS_X8 = 8;
  localparam int HDR_BITS_X16 = OP_BITS + ADDR_BITS_X16;
  localparam int HDR_BITS_X8 = OP_BITS + ADDR_BITS_X8;
  localparam int MEM_BYTES = 256;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_MS = 10;
  localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SCLK_HALF_NS = 500;
  localparam int SCLK_HALF_CYCLES =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_GAP_NS = 250;
  localparam int CS_GAP_CYCLES =
    (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* sep_link_if.sv */
// Four-wire serial link between host and memory
`timescale 1ns/1ns
interface sep_link_if;
  logic cs;
  logic sclk;
  logic din;
  logic q;
  logic q_oe_n;
  wire q_line;
  // Undriven output reads high, as with a pull-up
  assign q_line = q_oe_n ? 1'b1 : q;
  modport dev (input cs, input sclk, input din, output q, output q_oe_n);
  modport host (output cs, output sclk, output din, input q_line);
endinterface

/* sep_device.sv */
// Serial memory end: command decoder, array and program timer
//
`timescale 1ns/1ns
module sep_device #(
  parameter int PROG_CYCLES = sep_pkg::PROG_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic org_x16_in,
  output logic unlocked_out,
  output logic busy_out,
  sep_link_if.dev link
);
  import sep_pkg::*;

  localparam int PW = $clog2(PROG_CYCLES + 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_HDR, ST_DATA, ST_READ, ST_ARM, ST_SKIP, ST_BUSY
  } sep_dev_st_e;

  sep_dev_st_e state_reg;
  logic [2:0] cs_sync_reg;
  logic [2:0] ck_sync_reg;
  logic [1:0] di_sync_reg;
  logic [1:0] org_sync_reg;
  logic [4:0] cnt_reg;
  logic [15:0] sh_reg;
  logic [15:0] out_reg;
  logic [1:0] op_reg;
  logic [1:0] sub_reg;
  logic [8:0] addr_reg;
  logic q_reg;
  logic q_oe_n_reg;
  logic unlock_reg;
  logic ready_reg;
  logic [PW-1:0] prog_cnt_reg;
  logic [7:0] mem [MEM_BYTES];

  // Byte index of a location; the top address bit is dropped
  function automatic logic [7:0] byte_idx(input logic [8:0] a,
                                          input logic x16,
                                          input logic lo);
    byte_idx = x16 ? {a[6:0], lo} : a[7:0];
  endfunction

  // Location contents, left aligned in sixteen bits
  function automatic logic [15:0] rd_word(input logic [8:0] a,
                                          input logic x16);
    if (x16) begin
      rd_word = {mem[byte_idx(a, 1'b1, 1'b0)], mem[byte_idx(a, 1'b1, 1'b1)]};
    end else begin
      rd_word = {mem[byte_idx(a, 1'b0, 1'b0)], 8'h00};
    end
  endfunction

  // Synchronised pins and their edges
  wire cs = cs_sync_reg[1];
  wire ck_rise = ck_sync_reg[1] & ~ck_sync_reg[2];
  wire cs_fall = ~cs_sync_reg[1] & cs_sync_reg[2];
  wire din = di_sync_reg[1];
  wire x16 = org_sync_reg[1];

  // Instruction field decode
  wire [4:0] hdr_last = x16 ? 5'(HDR_BITS_X16 - 1) : 5'(HDR_BITS_X8 - 1);
  wire [4:0] data_last = x16 ? 5'(DATA_BITS_X16 - 1) : 5'(DATA_BITS_X8 - 1);
  wire [4:0] data_len = x16 ? 5'(DATA_BITS_X16) : 5'(DATA_BITS_X8);
  wire [10:0] hdr_word = {sh_reg[9:0], din};
  wire [1:0] op_now = x16 ? hdr_word[9:8] : hdr_word[10:9];
  wire [8:0] addr_now = x16 ? {1'b0, hdr_word[7:0]} : hdr_word[8:0];
  wire [1:0] sub_now = x16 ? addr_now[7:6] : addr_now[8:7];
  wire [8:0] addr_inc = addr_reg + 9'h001;
  wire [15:0] wdata = x16 ? sh_reg : {sh_reg[7:0], 8'h00};
  wire [15:0] sh_in = {sh_reg[14:0], din};

  // Program start, completion and output drive
  wire mem_go = (state_reg == ST_ARM) & cs_fall & unlock_reg;
  wire prog_done = prog_cnt_reg == PW'(PROG_CYCLES - 1);
  wire drive = cs & ((state_reg == ST_READ) | (state_reg == ST_BUSY) |
                     ready_reg);

  // Pin synchronisers, two flops before any use
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cs_sync_reg <= 3'h0;
      ck_sync_reg <= 3'h0;
      di_sync_reg <= 2'h0;
      org_sync_reg <= 2'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], link.cs};
      ck_sync_reg <= {ck_sync_reg[1:0], link.sclk};
      di_sync_reg <= {di_sync_reg[0], link.din};
      org_sync_reg <= {org_sync_reg[0], org_x16_in};
    end
  end

  // Command sequencer
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
      sh_reg <= 16'h0000;
      out_reg <= 16'h0000;
      op_reg <= OP_READ;
      sub_reg <= SUB_LOCK;
      addr_reg <= 9'h000;
      q_reg <= 1'b0;
      q_oe_n_reg <= 1'b1;
      unlock_reg <= 1'b0;
      ready_reg <= 1'b0;
      prog_cnt_reg <= '0;
    end else begin
      q_oe_n_reg <= ~drive;
      if (state_reg == ST_BUSY) begin
        // Timed on the core clock, deaf to the link
        q_reg <= 1'b0;
        prog_cnt_reg <= prog_cnt_reg + PW'(1);
        if (prog_done) begin
          state_reg <= ST_IDLE;
          ready_reg <= 1'b1;
          q_reg <= 1'b1;
        end
      end else if (state_reg == ST_ARM && cs_fall) begin
        // Start the cycle only when unlocked
        if (unlock_reg) begin
          state_reg <= ST_BUSY;
          prog_cnt_reg <= '0;
        end else begin
          state_reg <= ST_IDLE;
        end
      end else if (!cs) begin
        state_reg <= ST_IDLE;
        ready_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (ck_rise && din) begin
              state_reg <= ST_HDR;
              cnt_reg <= 5'h00;
              ready_reg <= 1'b0;
            end
          end
          ST_HDR: begin
            if (ck_rise) begin
              sh_reg <= sh_in;
              cnt_reg <= cnt_reg + 5'h01;
              if (cnt_reg == hdr_last) begin
                op_reg <= op_now;
                sub_reg <= sub_now;
                addr_reg <= addr_now;
                cnt_reg <= 5'h00;
                case (op_now)
                  OP_READ: begin
                    // Leading zero, data follows on later rises
                    state_reg <= ST_READ;
                    q_reg <= 1'b0;
                    out_reg <= rd_word(addr_now, x16);
                    cnt_reg <= data_len;
                  end
                  OP_WRITE: state_reg <= ST_DATA;
                  OP_ERASE: state_reg <= ST_ARM;
                  default: begin
                    case (sub_now)
                      SUB_UNLOCK: begin
                        unlock_reg <= 1'b1;
                        state_reg <= ST_SKIP;
                      end
                      SUB_LOCK: begin
                        unlock_reg <= 1'b0;
                        state_reg <= ST_SKIP;
                      end
                      SUB_CLEAR: state_reg <= ST_ARM;
                      default: state_reg <= ST_DATA;
                    endcase
                  end
                endcase
              end
            end
          end
          ST_DATA: begin
            if (ck_rise) begin
              sh_reg <= sh_in;
              cnt_reg <= cnt_reg + 5'h01;
              if (cnt_reg == data_last) begin
                state_reg <= ST_ARM;
              end
            end
          end
          ST_READ: begin
            if (ck_rise) begin
              q_reg <= out_reg[15];
              if (cnt_reg == 5'h01) begin
                // Next location, no leading zero this time
                addr_reg <= addr_inc;
                out_reg <= rd_word(addr_inc, x16);
                cnt_reg <= data_len;
              end else begin
                out_reg <= {out_reg[14:0], 1'b0};
                cnt_reg <= cnt_reg - 5'h01;
              end
            end
          end
          ST_ARM: begin
            // A clock rise before select falls cancels the command
            if (ck_rise) begin
              state_reg <= ST_SKIP;
            end
          end
          default: state_reg <= ST_SKIP;
        endcase
      end
    end
  end

  // Array: erased after reset, altered only at program start
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= ERASED_BYTE;
      end
    end else if (mem_go) begin
      case (op_reg)
        OP_WRITE: begin
          // Whole location replaced, so no erase is needed first
          mem[byte_idx(addr_reg, x16, 1'b0)] <= wdata[15:8];
          if (x16) begin
            mem[byte_idx(addr_reg, 1'b1, 1'b1)] <= wdata[7:0];
          end
        end
        OP_ERASE: begin
          mem[byte_idx(addr_reg, x16, 1'b0)] <= ERASED_BYTE;
          if (x16) begin
            mem[byte_idx(addr_reg, 1'b1, 1'b1)] <= ERASED_BYTE;
          end
        end
        OP_SPECIAL: begin
          for (int i = 0; i < MEM_BYTES; i++) begin
            if (sub_reg == SUB_FILL) begin
              mem[i] <= (x16 && i[0]) ? wdata[7:0] : wdata[15:8];
            end else begin
              mem[i] <= ERASED_BYTE;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // Outputs
  assign link.q = q_reg;
  assign link.q_oe_n = q_oe_n_reg;
  assign unlocked_out = unlock_reg;
  assign busy_out = state_reg == ST_BUSY;
endmodule

/* sep_host.sv */
// Host end: turns commands into serial instructions
`timescale 1ns/1ns
module sep_host #(
  parameter int HALF_CYCLES = sep_pkg::SCLK_HALF_CYCLES,
  parameter int GAP_CYCLES = sep_pkg::CS_GAP_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic org_x16_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic [1:0] cmd_op_in,
  input wire logic [8:0] cmd_addr_in,
  input wire logic [15:0] cmd_data_in,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output logic done_out,
  sep_link_if.host link
);
  import sep_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_SHIFT, H_GAP, H_POLL
  } sep_host_st_e;

  sep_host_st_e state_reg;
  logic [15:0] div_reg;
  logic [27:0] tx_reg;
  logic [5:0] cnt_reg;
  logic [15:0] rx_reg;
  logic [1:0] q_sync_reg;
  logic cs_reg;
  logic ck_reg;
  logic prog_reg;
  logic rd_reg;
  logic x16_reg;
  logic rsp_valid_reg;
  logic done_reg;
  logic [15:0] rsp_data_reg;

  // Command classification
  wire [1:0] sub = org_x16_in ? cmd_addr_in[7:6] : cmd_addr_in[8:7];
  wire special = cmd_op_in == OP_SPECIAL;
  wire has_data = (cmd_op_in == OP_WRITE) | (special & (sub == SUB_FILL));
  wire is_prog = (cmd_op_in == OP_WRITE) | (cmd_op_in == OP_ERASE) |
                 (special & ((sub == SUB_FILL) | (sub == SUB_CLEAR)));
  wire is_read = cmd_op_in == OP_READ;

  // Start bit, op-code, address and data, MSB first
  wire [27:0] frame_x16 = {1'b1, cmd_op_in, cmd_addr_in[7:0],
                           is_read ? 16'h0000 : cmd_data_in, 1'b0};
  wire [27:0] frame_x8 = {1'b1, cmd_op_in, cmd_addr_in,
                          is_read ? 8'h00 : cmd_data_in[7:0], 8'h00};
  wire [5:0] hdr_n = org_x16_in ? 6'(1 + HDR_BITS_X16) : 6'(1 + HDR_BITS_X8);
  wire [5:0] dat_n = org_x16_in ? 6'(DATA_BITS_X16) : 6'(DATA_BITS_X8);
  // Dummy zero comes with the last address rise, so reads need no extra bit
  wire [5:0] total_n = hdr_n + ((has_data | is_read) ? dat_n : 6'h00);

  wire tick = div_reg == 16'(HALF_CYCLES - 1);
  wire gap_end = div_reg == 16'(GAP_CYCLES - 1);
  wire q_in = q_sync_reg[1];
  wire accept = (state_reg == H_IDLE) & cmd_valid_in;
  // Gap wait counts past the half-period tick
  wire div_clr = (tick & (state_reg != H_GAP)) | (state_reg == H_IDLE);

  // Returned line synchroniser
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      q_sync_reg <= 2'h0;
    end else begin
      q_sync_reg <= {q_sync_reg[0], link.q_line};
    end
  end

  // Instruction sequencer
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= H_IDLE;
      div_reg <= 16'h0000;
      tx_reg <= 28'h0000000;
      cnt_reg <= 6'h00;
      rx_reg <= 16'h0000;
      cs_reg <= 1'b0;
      ck_reg <= 1'b0;
      prog_reg <= 1'b0;
      rd_reg <= 1'b0;
      x16_reg <= 1'b1;
      rsp_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      rsp_data_reg <= 16'h0000;
    end else begin
      rsp_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      div_reg <= div_clr ? 16'h0000 : div_reg + 16'h0001;
      case (state_reg)
        H_IDLE: begin
          if (accept) begin
            // Select rises with the clock low
            state_reg <= H_SETUP;
            cs_reg <= 1'b1;
            tx_reg <= org_x16_in ? frame_x16 : frame_x8;
            cnt_reg <= total_n;
            prog_reg <= is_prog;
            rd_reg <= is_read;
            x16_reg <= org_x16_in;
          end
        end
        H_SETUP: begin
          if (tick) begin
            state_reg <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick) begin
            ck_reg <= ~ck_reg;
            if (ck_reg) begin
              // Falling edge: capture reply, present next bit
              rx_reg <= {rx_reg[14:0], q_in};
              tx_reg <= {tx_reg[26:0], 1'b0};
              cnt_reg <= cnt_reg - 6'h01;
              if (cnt_reg == 6'h01) begin
                cs_reg <= 1'b0;
                div_reg <= 16'h0000;
                state_reg <= H_GAP;
              end
            end
          end
        end
        H_GAP: begin
          // Select held low between instructions
          if (gap_end) begin
            div_reg <= 16'h0000;
            if (prog_reg) begin
              state_reg <= H_POLL;
              cs_reg <= 1'b1;
            end else begin
              state_reg <= H_IDLE;
              done_reg <= 1'b1;
              rsp_valid_reg <= rd_reg;
              rsp_data_reg <= x16_reg ? rx_reg : {8'h00, rx_reg[7:0]};
            end
          end
        end
        H_POLL: begin
          // Wait for the ready level on the returned line
          if (tick && q_in) begin
            cs_reg <= 1'b0;
            prog_reg <= 1'b0;
            div_reg <= 16'h0000;
            state_reg <= H_GAP;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // Outputs
  assign link.cs = cs_reg;
  assign link.sclk = ck_reg;
  assign link.din = tx_reg[27];
  assign cmd_ready_out = state_reg == H_IDLE;
  assign rsp_valid_out = rsp_valid_reg;
  assign rsp_data_out = rsp_data_reg;
  assign done_out = done_reg;
endmodule

/* sep_link_monitor.sv */
// Protocol checker for the serial memory link
`timescale 1ns/1ns
module sep_link_monitor #(
  parameter int PROG_CYCLES = 200,
  parameter int GAP_CYCLES = 32
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic cs_in,
  input wire logic sclk_in,
  input wire logic din_in,
  input wire logic q_in,
  input wire logic q_oe_n_in,
  input wire logic busy_in
);
  logic [7:0] low_cnt_reg;
  logic [31:0] busy_cnt_reg;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  // Cycles with select low, saturating; full after reset
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in)
      low_cnt_reg <= 8'hff;
    else if (cs_in)
      low_cnt_reg <= 8'h00;
    else if (low_cnt_reg != 8'hff)
      low_cnt_reg <= low_cnt_reg + 8'h01;
  end

  // Length of the current self-timed cycle
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !busy_in)
      busy_cnt_reg <= 32'h0;
    else
      busy_cnt_reg <= busy_cnt_reg + 32'h1;
  end

  // Link framing and timing
  a_gap_before_sel: assert property (
    $rose(cs_in) |-> low_cnt_reg >= GAP_CYCLES)
    else $error("select gap too short");
  a_sel_clk_low: assert property ($rose(cs_in) |-> !sclk_in)
    else $error("select rose with clock high");
  a_drop_clk_low: assert property ($fell(cs_in) |-> !sclk_in)
    else $error("select fell with clock high");
  a_din_hold_high: assert property (
    sclk_in && $past(sclk_in) |-> $stable(din_in))
    else $error("data moved while clock high");
  // Programming cycle and status output
  a_busy_drives_low: assert property (
    (cs_in && busy_in) [*8] |-> !q_oe_n_in && !q_in)
    else $error("busy not shown as low");
  a_busy_starts_idle: assert property ($rose(busy_in) |-> !cs_in)
    else $error("program cycle began with select high");
  a_prog_bounded: assert property (
    busy_in |-> busy_cnt_reg < PROG_CYCLES + 2)
    else $error("program cycle overran");
  a_prog_full: assert property (
    $fell(busy_in) |-> busy_cnt_reg >= PROG_CYCLES - 1)
    else $error("program cycle ended early");
  a_ready_after_prog: assert property (
    $fell(busy_in) ##0 cs_in [*6] |-> q_in && !q_oe_n_in)
    else $error("ready not shown after cycle");
  a_hiz_when_idle: assert property (!cs_in [*8] |-> q_oe_n_in)
    else $error("output driven with select low");

  // Main scenarios reached
  c_prog: cover property ($rose(busy_in));
  c_ready: cover property ($fell(busy_in) ##0 cs_in [*6]);
  c_drive: cover property (!q_oe_n_in && sclk_in && !busy_in);
endmodule

/* tb.sv */
// Self-checking bench: host and memory ends joined by the serial link
`timescale 1ns/1ns
module tb;
  import sep_pkg::*;
  localparam int PROG = 200;
  localparam int HALF = 8;
  localparam int GAP = 32;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic org_x16 = 1'b1;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [8:0] cmd_addr = 9'h000;
  logic [15:0] cmd_data = 16'h0000;
  logic cmd_ready, rsp_valid, done, unlocked, busy, en;
  logic [15:0] rsp_data;
  logic [31:0] frame = 32'h0;
  logic [7:0] mem [0:255];
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 32'h7b24;

  always #4 core_clk_in = ~core_clk_in;

  sep_link_if i_sep_link_if ();
  sep_device #(.PROG_CYCLES(PROG)) i_sep_device (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .org_x16_in(org_x16), .unlocked_out(unlocked), .busy_out(busy),
    .link(i_sep_link_if));
  sep_host #(.HALF_CYCLES(HALF), .GAP_CYCLES(GAP)) i_sep_host (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .org_x16_in(org_x16), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op), .cmd_addr_in(cmd_addr),
    .cmd_data_in(cmd_data), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data), .done_out(done), .link(i_sep_link_if));
  sep_link_monitor #(.PROG_CYCLES(PROG), .GAP_CYCLES(GAP)) i_sep_link_monitor (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .cs_in(i_sep_link_if.cs), .sclk_in(i_sep_link_if.sclk),
    .din_in(i_sep_link_if.din), .q_in(i_sep_link_if.q),
    .q_oe_n_in(i_sep_link_if.q_oe_n), .busy_in(busy));

  // Bits seen by the memory end, oldest first
  always @(posedge i_sep_link_if.sclk)
    if (i_sep_link_if.cs) frame <= {frame[30:0], i_sep_link_if.din};

  // Expected word at one location, top address bit dropped
  function automatic logic [15:0] exp_word(input logic [8:0] a);
    logic [7:0] i;
    i = org_x16 ? {a[6:0], 1'b0} : a[7:0];
    return org_x16 ? {mem[i], mem[i + 8'h01]} : {8'h00, mem[i]};
  endfunction

  // Address carrying a special sub-op in its top bits
  function automatic logic [8:0] sub_addr(input logic [1:0] s);
    return org_x16 ? {1'b0, s, 6'h00} : {s, 7'h00};
  endfunction

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Shadow array update for one finished command
  task automatic model(input logic [1:0] op, input logic [8:0] a,
                       input logic [15:0] d);
    logic [7:0] i;
    logic [1:0] s;
    i = org_x16 ? {a[6:0], 1'b0} : a[7:0];
    s = org_x16 ? a[7:6] : a[8:7];
    if (op == OP_SPECIAL && s == SUB_UNLOCK) en = 1'b1;
    if (op == OP_SPECIAL && s == SUB_LOCK) en = 1'b0;
    if (!en) return;
    for (int k = 0; k < 256; k++) begin
      if (op == OP_SPECIAL && s == SUB_CLEAR) mem[k] = 8'hff;
      if (op == OP_SPECIAL && s == SUB_FILL)
        mem[k] = (org_x16 && !k[0]) ? d[15:8] : d[7:0];
    end
    if (op == OP_ERASE || op == OP_WRITE) begin
      mem[i] = op == OP_ERASE ? 8'hff : (org_x16 ? d[15:8] : d[7:0]);
      if (org_x16) mem[i + 8'h01] = op == OP_ERASE ? 8'hff : d[7:0];
    end
  endtask

  // One command through the host port, bounded wait for completion
  task automatic run_cmd(input logic [1:0] op, input logic [8:0] a,
                         input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge core_clk_in);
    cmd_valid <= 1'b0;
    do begin
      @(posedge core_clk_in);
      #1;
      n++;
    end while (done !== 1'b1 && n < 5000);
    check("done", 32'h1, 32'(done));
    check("cmd ready", 32'h1, 32'(cmd_ready));
    check("busy", 32'h0, 32'(busy));
  endtask

  task automatic prog(input logic [1:0] op, input logic [8:0] a,
                      input logic [15:0] d);
    run_cmd(op, a, d);
    model(op, a, d);
    check("unlock flag", 32'(en), 32'(unlocked));
    check("no read pulse", 32'h0, 32'(rsp_valid));
  endtask

  task automatic read_chk(input logic [8:0] a);
    run_cmd(OP_READ, a, 16'h0000);
    check("read pulse", 32'h1, 32'(rsp_valid));
    check("read data", 32'(exp_word(a)), 32'(rsp_data));
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Both organisations, each after its own reset
  initial begin
    logic [8:0] a, top;
    logic [15:0] d;
    for (int o = 1; o >= 0; o--) begin
      @(posedge core_clk_in);
      sys_rst_in <= 1'b1;
      org_x16 <= o[0];
      en = 1'b0;
      for (int k = 0; k < 256; k++) mem[k] = 8'hff;
      repeat (6) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      top = org_x16 ? 9'h080 : 9'h100;
      read_chk(9'h1ff);
      prog(OP_WRITE, 9'h005, 16'h1234);
      read_chk(9'h005);
      prog(OP_SPECIAL, sub_addr(SUB_UNLOCK), 16'h0000);
      for (int k = 0; k < 4; k++) begin
        a = 9'($random(seed));
        d = 16'($random(seed));
        if (!org_x16) d = {8'h00, d[7:0]};
        prog(OP_WRITE, a, d);
        check("write frame", org_x16 ? 32'({1'b1, OP_WRITE, a[7:0], d})
          : 32'({1'b1, OP_WRITE, a, d[7:0]}),
          org_x16 ? 32'(frame[26:0]) : 32'(frame[19:0]));
        read_chk(a ^ top);
      end
      prog(OP_ERASE, a, 16'h0000);
      read_chk(a);
      prog(OP_SPECIAL, sub_addr(SUB_FILL),
        org_x16 ? 16'ha55a : 16'h003c);
      read_chk(9'($random(seed)));
      prog(OP_SPECIAL, sub_addr(SUB_CLEAR), 16'h0000);
      read_chk(9'h000);
      prog(OP_WRITE, a, d);
      prog(OP_SPECIAL, sub_addr(SUB_LOCK), 16'h0000);
      prog(OP_WRITE, a, ~d);
      read_chk(a);
    end
    report_and_stop();
  end

  // Hang guard, well beyond the expected run length
  initial begin
    repeat (80000) @(posedge core_clk_in);
    n_fail++;
    report_and_stop();
  end
endmodule
